// File: flash_tpm_serial_port.sv
// Serial port master toward two flash memories and one trust module
`timescale 1ns/1ps
`include "flash_tpm_port_regs.svh"

module flash_tpm_serial_port #(
  parameter int BYTE_W   = 8,
  parameter int LEN_W    = 8,
  parameter int HALF_W   = 4
) (
  // System side
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              resume_well_reset_n,
  input  wire logic              sleep_state,
  // Straps
  input  wire logic              trust_module_on_serial,
  input  wire logic              wide_io_strap,
  input  wire logic [1:0]        rate_sel,
  input  wire logic              fast_flash_ok,
  // Transfer request (system clock)
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_target,
  input  wire logic [1:0]        req_lanes,
  input  wire logic [LEN_W-1:0]  req_out_bytes,
  input  wire logic [LEN_W-1:0]  req_in_bytes,
  input  wire logic [BYTE_W-1:0] req_wdata,
  output logic                   wdata_take,
  output logic [BYTE_W-1:0]      rdata,
  output logic                   rdata_valid,
  output logic                   xfer_done,
  output logic                   req_error,
  // Link clock
  input  wire logic              link_clk,
  // Pins
  output logic                   serial_clock_out,
  output logic                   serial_clock_oe,
  output logic                   primary_flash_select_n,
  output logic                   secondary_flash_select_n,
  output logic                   trust_module_select_n,
  output logic                   select_oe,
  input  wire logic              host_out_line_in,
  output logic                   host_out_line,
  output logic                   host_out_line_oe,
  input  wire logic              host_in_line_in,
  output logic                   host_in_line_out,
  output logic                   host_in_line_oe,
  input  wire logic [1:0]        extra_data_lines_hi_in,
  output logic [1:0]             extra_data_lines_hi_out,
  output logic [1:0]             extra_data_lines_hi_oe
);

  // --------------------------------------------------------------------------
  // Pin release and straps
  // --------------------------------------------------------------------------
  logic rsm_s1_q;
  logic rsm_q;
  logic slp_s1_q;
  logic slp_q;
  logic strap_tm_q;
  logic strap_wide_q;
  logic [1:0] strap_rate_q;
  logic strap_fast_q;
  logic busy_q;

  // Resume reset and sleep come from other wells: two flops each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsm_s1_q <= 1'b0;
      rsm_q    <= 1'b0;
      slp_s1_q <= 1'b1;
      slp_q    <= 1'b1;
    end else begin
      rsm_s1_q <= resume_well_reset_n;
      rsm_q    <= rsm_s1_q;
      slp_s1_q <= sleep_state;
      slp_q    <= slp_s1_q;
    end
  end

  // Straps caught while pins still released, frozen afterwards
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_tm_q   <= 1'b0;
      strap_wide_q <= 1'b0;
      strap_rate_q <= `RATE_SEL_17;
      strap_fast_q <= 1'b0;
    end else if (!rsm_q) begin
      strap_tm_q   <= trust_module_on_serial;
      strap_wide_q <= wide_io_strap;
      strap_fast_q <= fast_flash_ok;
      // Without 66 MHz capable flash the top rate falls back
      if (rate_sel == `RATE_SEL_48 && !fast_flash_ok) begin
        strap_rate_q <= `RATE_SEL_30;
      end else if (rate_sel > `RATE_SEL_48) begin
        strap_rate_q <= `RATE_SEL_17;
      end else begin
        strap_rate_q <= rate_sel;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request capture (system clock) and handshake to link
  // --------------------------------------------------------------------------
  logic              go_tgl_q;
  logic              done_tgl_s1_q;
  logic              done_tgl_s2_q;
  logic              done_tgl_s3_q;
  logic [1:0]        tgt_q;
  logic [1:0]        lanes_q;
  logic [LEN_W-1:0]  out_n_q;
  logic [LEN_W-1:0]  in_n_q;
  logic              bad_req;

  // Wide lanes need the strap; third select only if module lives here
  always_comb begin
    bad_req = 1'b0;
    if (req_target == `TGT_TRUST && !strap_tm_q) begin
      bad_req = 1'b1;
    end
    if (req_target > `TGT_TRUST) begin
      bad_req = 1'b1;
    end
    if (req_target == `TGT_TRUST && req_lanes != flash_tpm_port_pkg::lane_single) begin
      bad_req = 1'b1;
    end
    if (req_lanes[1] && !strap_wide_q) begin
      bad_req = 1'b1;
    end
    if (req_lanes == flash_tpm_port_pkg::lane_dual_io && !strap_wide_q) begin
      bad_req = 1'b1;
    end
  end

  assign req_ready = rsm_q && !slp_q && !busy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      go_tgl_q  <= 1'b0;
      tgt_q     <= `TGT_PRIMARY;
      lanes_q   <= flash_tpm_port_pkg::lane_single;
      out_n_q   <= '0;
      in_n_q    <= '0;
      req_error <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      req_error <= 1'b0;
      xfer_done <= 1'b0;
      if (req_valid && req_ready) begin
        if (bad_req) begin
          req_error <= 1'b1;
        end else begin
          busy_q   <= 1'b1;
          go_tgl_q <= ~go_tgl_q;
          tgt_q    <= req_target;
          lanes_q  <= req_lanes;
          out_n_q  <= req_out_bytes;
          in_n_q   <= req_in_bytes;
        end
      end
      if (done_tgl_s2_q != done_tgl_s3_q) begin
        busy_q    <= 1'b0;
        xfer_done <= 1'b1;
      end
    end
  end

  // Byte toggles from link back to system clock
  logic take_tgl_s1_q;
  logic take_tgl_s2_q;
  logic take_tgl_s3_q;
  logic rd_tgl_s1_q;
  logic rd_tgl_s2_q;
  logic rd_tgl_s3_q;
  logic [BYTE_W-1:0] link_rbyte_q;
  logic              link_take_tgl_q;
  logic              link_rd_tgl_q;
  logic              link_done_tgl_q;
  logic [BYTE_W-1:0] wbyte_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_tgl_s1_q <= 1'b0;
      done_tgl_s2_q <= 1'b0;
      done_tgl_s3_q <= 1'b0;
      take_tgl_s1_q <= 1'b0;
      take_tgl_s2_q <= 1'b0;
      take_tgl_s3_q <= 1'b0;
      rd_tgl_s1_q   <= 1'b0;
      rd_tgl_s2_q   <= 1'b0;
      rd_tgl_s3_q   <= 1'b0;
    end else begin
      done_tgl_s1_q <= link_done_tgl_q;
      done_tgl_s2_q <= done_tgl_s1_q;
      done_tgl_s3_q <= done_tgl_s2_q;
      take_tgl_s1_q <= link_take_tgl_q;
      take_tgl_s2_q <= take_tgl_s1_q;
      take_tgl_s3_q <= take_tgl_s2_q;
      rd_tgl_s1_q   <= link_rd_tgl_q;
      rd_tgl_s2_q   <= rd_tgl_s1_q;
      rd_tgl_s3_q   <= rd_tgl_s2_q;
    end
  end

  // Next write byte held stable while link is mid byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wbyte_q     <= '0;
      wdata_take  <= 1'b0;
      rdata       <= '0;
      rdata_valid <= 1'b0;
    end else begin
      wdata_take  <= 1'b0;
      rdata_valid <= 1'b0;
      if ((req_valid && req_ready && !bad_req) || (take_tgl_s2_q != take_tgl_s3_q)) begin
        wbyte_q    <= req_wdata;
        wdata_take <= 1'b1;
      end
      if (rd_tgl_s2_q != rd_tgl_s3_q) begin
        rdata       <= link_rbyte_q;
        rdata_valid <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Link domain sequencer
  // --------------------------------------------------------------------------
  logic lrst_s1_q;
  logic lrst_n_q;
  logic go_s1_q;
  logic go_s2_q;
  logic go_s3_q;
  flash_tpm_port_pkg::link_state_t st_q;
  logic [HALF_W-1:0] half_cnt_q;
  logic [HALF_W-1:0] half_div;
  logic              sck_q;
  logic [2:0]        bit_q;
  logic [LEN_W-1:0]  left_q;
  logic              rx_phase_q;
  logic [BYTE_W-1:0] sh_q;
  logic [3:0]        lane_w;
  logic [3:0]        rx_in_bits;

  // Reset release into link domain
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q  <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q  <= lrst_s1_q;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_s1_q <= 1'b0;
      go_s2_q <= 1'b0;
      go_s3_q <= 1'b0;
    end else begin
      go_s1_q <= go_tgl_q;
      go_s2_q <= go_s1_q;
      go_s3_q <= go_s2_q;
    end
  end

  // Half period per rate; frozen strap is quasi-static
  always_comb begin
    case (strap_rate_q)
      `RATE_SEL_30: half_div = HALF_W'(`HALF_DIV_30);
      `RATE_SEL_48: half_div = HALF_W'(`HALF_DIV_48);
      default:      half_div = HALF_W'(`HALF_DIV_17);
    endcase
  end

  // Bits per edge: one for command phase, lanes for read phase
  always_comb begin
    lane_w = 4'h1;
    if (rx_phase_q) begin
      case (lanes_q)
        flash_tpm_port_pkg::lane_dual_out: lane_w = 4'h2;
        flash_tpm_port_pkg::lane_dual_io:  lane_w = 4'h2;
        flash_tpm_port_pkg::lane_quad:     lane_w = 4'h4;
        default:                           lane_w = 4'h1;
      endcase
    end
    rx_in_bits = {extra_data_lines_hi_in, host_in_line_in, host_out_line_in};
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= flash_tpm_port_pkg::st_idle;
      half_cnt_q      <= '0;
      sck_q           <= 1'b0;
      bit_q           <= '0;
      left_q          <= '0;
      rx_phase_q      <= 1'b0;
      sh_q            <= '0;
      link_rbyte_q    <= '0;
      link_take_tgl_q <= 1'b0;
      link_rd_tgl_q   <= 1'b0;
      link_done_tgl_q <= 1'b0;
    end else begin
      case (st_q)
        flash_tpm_port_pkg::st_idle: begin
          sck_q <= 1'b0;
          if (lrst_n_q && go_s2_q != go_s3_q) begin
            st_q       <= flash_tpm_port_pkg::st_shift;
            sh_q       <= wbyte_q;
            bit_q      <= '0;
            half_cnt_q <= '0;
            rx_phase_q <= (out_n_q == '0);
            left_q     <= (out_n_q == '0) ? in_n_q : out_n_q;
            link_take_tgl_q <= ~link_take_tgl_q;
          end
        end
        flash_tpm_port_pkg::st_shift: begin
          if (half_cnt_q + HALF_W'(1) >= half_div) begin
            half_cnt_q <= '0;
            sck_q      <= ~sck_q;
            if (sck_q) begin
              // Falling edge: move to next bit group
              if ({1'b0, bit_q} + lane_w >= 4'(BYTE_W)) begin
                bit_q  <= '0;
                left_q <= left_q - LEN_W'(1);
                if (rx_phase_q) begin
                  link_rbyte_q  <= sh_q;
                  link_rd_tgl_q <= ~link_rd_tgl_q;
                end
                if (left_q == LEN_W'(1)) begin
                  if (!rx_phase_q && in_n_q != '0) begin
                    rx_phase_q <= 1'b1;
                    left_q     <= in_n_q;
                  end else begin
                    st_q <= flash_tpm_port_pkg::st_done;
                  end
                end else if (!rx_phase_q) begin
                  sh_q            <= wbyte_q;
                  link_take_tgl_q <= ~link_take_tgl_q;
                end
              end else begin
                bit_q <= bit_q + 3'(lane_w);
                if (!rx_phase_q) begin
                  sh_q <= {sh_q[BYTE_W-2:0], 1'b0};
                end
              end
            end else if (rx_phase_q) begin
              // Rising edge: sample the active lanes
              case (lane_w)
                4'h4:    sh_q <= {sh_q[BYTE_W-5:0], rx_in_bits};
                4'h2:    sh_q <= {sh_q[BYTE_W-3:0], rx_in_bits[1:0]};
                default: sh_q <= {sh_q[BYTE_W-2:0], rx_in_bits[1]};
              endcase
            end
          end else begin
            half_cnt_q <= half_cnt_q + HALF_W'(1);
          end
        end
        flash_tpm_port_pkg::st_done: begin
          sck_q           <= 1'b0;
          link_done_tgl_q <= ~link_done_tgl_q;
          st_q            <= flash_tpm_port_pkg::st_idle;
        end
        default: st_q <= flash_tpm_port_pkg::st_idle;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  logic active;
  logic in_rx;

  // Sleep forces selects high and out line low even if a frame is cut
  assign active = (st_q == flash_tpm_port_pkg::st_shift) && !slp_q;
  assign in_rx  = active && rx_phase_q;

  always_comb begin
    serial_clock_oe          = rsm_q;
    select_oe                = rsm_q;
    serial_clock_out         = sck_q && !slp_q;
    // Only the latched target is ever pulled low
    primary_flash_select_n   = !(active && tgt_q == `TGT_PRIMARY);
    secondary_flash_select_n = !(active && tgt_q == `TGT_SECONDARY);
    trust_module_select_n    = !(active && tgt_q == `TGT_TRUST);
    host_out_line            = active && !in_rx && sh_q[BYTE_W-1];
    // Out line turns around only in dual I/O and quad read modes
    host_out_line_oe         = rsm_q && !(in_rx && lanes_q != flash_tpm_port_pkg::lane_single
                                          && lanes_q != flash_tpm_port_pkg::lane_dual_out);
    host_in_line_out         = 1'b0;
    host_in_line_oe          = 1'b0;
    extra_data_lines_hi_out  = 2'b00;
    extra_data_lines_hi_oe   = 2'b00;
  end

endmodule

// File: flash_tpm_port_regs.svh
// Timing counts and strap encodings for the flash and trust module serial port
// Contract
// - Three active-low selects, two flash, one module
// - First select drives only primary flash
// - Second select drives only secondary flash
// - Third select reserved for trust module
// - Strap routes trust module here or elsewhere
// - Serial clock at 17, 30 or 48 MHz; the 48 MHz code here uses the same one-tick half period as 30
// - Host out line output, strap makes bidirectional
// - Host in line input, strap makes bidirectional; the port never drives it
// - Extra lines used only in wide modes
// - Idle: clock low, out low, selects high
// - Idle: in and extra lines undriven
`ifndef FLASH_TPM_PORT_REGS_SVH
`define FLASH_TPM_PORT_REGS_SVH

// ----------------------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------------------
`define SYS_CLK_KHZ       10000
`define LINK_RATE_17_KHZ  17000
`define LINK_RATE_30_KHZ  30000
`define LINK_RATE_48_KHZ  48000
// Link ticks per serial clock half period at each rate (link runs at 66 MHz-ish)
`define HALF_DIV_17       2
`define HALF_DIV_30       1
`define HALF_DIV_48       1

// ----------------------------------------------------------------------------
// Rate select codes
// ----------------------------------------------------------------------------
`define RATE_SEL_17       2'h0
`define RATE_SEL_30       2'h1
`define RATE_SEL_48       2'h2

// ----------------------------------------------------------------------------
// Target select codes
// ----------------------------------------------------------------------------
`define TGT_PRIMARY       2'h0
`define TGT_SECONDARY     2'h1
`define TGT_TRUST         2'h2

`endif

// File: flash_tpm_port_pkg.sv
// Types shared by the flash and trust module serial port
package flash_tpm_port_pkg;

  // Lane usage during the data phase
  typedef enum logic [1:0] {
    lane_single   = 2'b00,
    lane_dual_out = 2'b01,
    lane_dual_io  = 2'b11,
    lane_quad     = 2'b10
  } lane_mode_t;

  // Link sequencer states, Gray coded along the transfer path
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_shift = 2'b01,
    st_done  = 2'b11
  } link_state_t;

endpackage

// File: port_assertions.sv
// Concurrent checks on the serial port pins and request side
`timescale 1ns/1ps
module port_assertions #(parameter int LEN_W = 8) (
  // Clocks, resets and power state
  input wire logic             clk, rst_n, link_clk, resume_well_reset_n, sleep_state,
  // Straps and request side
  input wire logic             trust_module_on_serial, wide_io_strap, req_valid, req_ready,
  input wire logic [1:0]       req_target, req_lanes,
  input wire logic [LEN_W-1:0] req_out_bytes,
  input wire logic             wdata_take, req_error,
  // Pins
  input wire logic             serial_clock_out, serial_clock_oe, select_oe, host_out_line,
  input wire logic             host_out_line_oe, host_in_line_oe,
  input wire logic             primary_flash_select_n, secondary_flash_select_n,
  input wire logic             trust_module_select_n,
  input wire logic [1:0]       extra_data_lines_hi_oe
);
  // ---------------------------------------------------------------
  // Helpers and system clock checks
  // ---------------------------------------------------------------
  wire take   = req_valid && req_ready;
  wire all_hi = primary_flash_select_n && secondary_flash_select_n && trust_module_select_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_one_select;
    $onehot0({~primary_flash_select_n, ~secondary_flash_select_n, ~trust_module_select_n});
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects low");
  property p_tristate;
    !resume_well_reset_n[*3] |-> !serial_clock_oe && !select_oe && !host_out_line_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins driven in reset");
  property p_in_float; !host_in_line_oe; endproperty
  a_in_float: assert property (p_in_float) else $error("host in line driven");
  property p_extra_float; extra_data_lines_hi_oe == 2'h0; endproperty
  a_extra_float: assert property (p_extra_float) else $error("extra lines driven");
  // Synchroniser needs two edges, so four cycles of sleep is safe
  property p_sleep_idle;
    sleep_state[*4] |-> !req_ready && !serial_clock_out && !host_out_line && all_hi;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("pins busy in sleep");
  property p_bad_target; take && req_target == 2'h3 |=> req_error; endproperty
  a_bad_target: assert property (p_bad_target) else $error("target 3 taken");
  property p_trust_strap;
    take && req_target == 2'h2 && !trust_module_on_serial |=> req_error;
  endproperty
  a_trust_strap: assert property (p_trust_strap) else $error("module not on port");
  property p_wide_strap; take && req_lanes[1] && !wide_io_strap |=> req_error; endproperty
  a_wide_strap: assert property (p_wide_strap) else $error("wide lanes unstrapped");
  property p_accept;
    take && req_target == 2'h0 && req_lanes == 2'h0 && req_out_bytes != 0
      |=> wdata_take && !req_error;
  endproperty
  a_accept: assert property (p_accept) else $error("good request refused");
  // ---------------------------------------------------------------
  // Link clock checks
  // ---------------------------------------------------------------
  property p_sck_in_frame;
    @(posedge link_clk) disable iff (!rst_n) serial_clock_out |-> !all_hi;
  endproperty
  a_sck_in_frame: assert property (p_sck_in_frame) else $error("clock outside frame");
  // A single-lane byte is at least sixteen link ticks (a quad read byte only four), so a shorter select is a glitch
  property p_select_hold;
    @(posedge link_clk) disable iff (!rst_n)
      $fell(primary_flash_select_n) |-> !primary_flash_select_n[*8];
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("select glitch");
  c_trust: cover property (take && req_target == 2'h2);
  c_refused: cover property (req_error);
  c_sleep: cover property (sleep_state[*4]);
endmodule

// File: serial_target_model.sv
// Behavioural flash and trust module model on the shared serial lines
`timescale 1ns/1ps
module serial_target_model (
  // Pins as the attached devices see them
  input wire logic sck, sel0_n, sel1_n, sel2_n, mosi,
  // Read data drive toward the host in line
  output logic     miso_drv,
  output logic     miso_oe
);
  // ---------------------------------------------------------------
  // Capture and answer
  // ---------------------------------------------------------------
  // Room for a command and at most seven further bytes
  logic [7:0] cap [0:7];
  logic [7:0] sh, drv;
  logic [2:0] seen;
  int         ncap, nbit, period;
  realtime    t_rise;
  wire        sel_n = sel0_n & sel1_n & sel2_n;
  // Each device answers its own byte so a misrouted select shows
  function automatic logic [7:0] pick();
    return !sel0_n ? 8'h3C : !sel1_n ? 8'hC3 : 8'h5A;
  endfunction
  initial begin
    seen = 3'h0;
    t_rise = 0;
  end
  // Frame start: first bit shown before the first rising edge
  always @(negedge sel_n) begin
    nbit = 0;
    ncap = 0;
    drv = pick();
    seen = seen | {~sel2_n, ~sel1_n, ~sel0_n};
  end
  // Host out sampled on rising clock, most significant bit first
  always @(posedge sck) if (!sel_n) begin
    sh = {sh[6:0], mosi};
    nbit++;
    if (nbit % 8 == 0 && ncap < 8) begin
      cap[ncap] = sh;
      ncap++;
    end
    period = int'($realtime - t_rise);
    t_rise = $realtime;
  end
  // Next bit after each falling edge; pull-up takes the line when released
  always @(negedge sck) if (!sel_n) drv = pick() << (nbit % 8);
  assign miso_drv = drv[7];
  assign miso_oe  = !sel_n;
endmodule

// File: testbench.sv
// Self-checking bench for the flash and trust module serial port
`timescale 1ns/1ps
module testbench;
  logic       clk, rst_n, link_clk, resume_n, sleep, trust_strap, wide_strap, fast_ok;
  logic       req_valid;
  logic [1:0] rate, tgt, lanes;
  logic [7:0] out_n, in_n, wdata;
  logic [7:0] rd_q [$];
  int         miscompares, n_checks, nerr;
  wire        req_ready, wdata_take, rdata_valid, xfer_done, req_error;
  wire  [7:0] rdata;
  wire        sck, sck_oe, cs0, cs1, cs2, cs_oe, mosi, mosi_oe, miso_o, miso_oe, p_bit, p_oe;
  wire  [1:0] x_o, x_oe;
  // Line levels from every party's enable; released lines sit at the pull-up
  wire        mosi_w = mosi_oe ? mosi : 1'b1;
  wire        miso_w = miso_oe ? miso_o : (p_oe ? p_bit : 1'b1);
  wire  [1:0] x_w    = (x_o & x_oe) | ~x_oe;
  flash_tpm_serial_port dut_u (.clk(clk), .rst_n(rst_n), .resume_well_reset_n(resume_n),
    .sleep_state(sleep), .trust_module_on_serial(trust_strap), .wide_io_strap(wide_strap),
    .rate_sel(rate), .fast_flash_ok(fast_ok), .req_valid(req_valid), .req_ready(req_ready),
    .req_target(tgt), .req_lanes(lanes), .req_out_bytes(out_n), .req_in_bytes(in_n),
    .req_wdata(wdata), .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid),
    .xfer_done(xfer_done), .req_error(req_error), .link_clk(link_clk),
    .serial_clock_out(sck), .serial_clock_oe(sck_oe), .primary_flash_select_n(cs0),
    .secondary_flash_select_n(cs1), .trust_module_select_n(cs2), .select_oe(cs_oe),
    .host_out_line_in(mosi_w), .host_out_line(mosi), .host_out_line_oe(mosi_oe),
    .host_in_line_in(miso_w), .host_in_line_out(miso_o), .host_in_line_oe(miso_oe),
    .extra_data_lines_hi_in(x_w), .extra_data_lines_hi_out(x_o),
    .extra_data_lines_hi_oe(x_oe));
  serial_target_model model_u (.sck(sck), .sel0_n(cs0), .sel1_n(cs1), .sel2_n(cs2),
    .mosi(mosi_w), .miso_drv(p_bit), .miso_oe(p_oe));
  // ---------------------------------------------------------------
  // Clocks, compare and closing
  // ---------------------------------------------------------------
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Link clock offset so its edges never line up with the system clock
  initial begin
    link_clk = 0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One request, held until taken, then followed to its end under a bound
  task automatic xfer(logic [1:0] t, l, logic [7:0] no, ni, b0, b1);
    int k;
    k = 0;
    rd_q = {};
    nerr = 0;
    @(negedge clk);
    {tgt, lanes, out_n, in_n, wdata} = {t, l, no, ni, b0};
    req_valid = 1;
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 0;
    k = 0;
    // Answer pulses stand right after the taking edge, so look before waiting
    do begin
      if (k > 0) @(negedge clk);
      k++;
      if (wdata_take === 1'b1) wdata = b1;
      if (rdata_valid === 1'b1) rd_q.push_back(rdata);
      if (req_error === 1'b1) nerr++;
    end while (xfer_done !== 1'b1 && req_error !== 1'b1 && k < 4000);
    chk("xfer_end", k < 4000, 1);
  endtask
  // Straps are latched only while the resume reset is held
  task automatic restrap(logic tr, w, logic [1:0] r, logic f);
    @(negedge clk);
    {resume_n, trust_strap, wide_strap, rate, fast_ok} = {1'b0, tr, w, r, f};
    repeat (4) @(negedge clk);
    chk("pins_tristate", {sck_oe, cs_oe, mosi_oe, miso_oe, x_oe}, 6'h00);
    resume_n = 1;
    repeat (4) @(negedge clk);
    chk("idle_pins", {sck, mosi, cs0, cs1, cs2, cs_oe}, 6'h0F);
    chk("idle_float", {miso_oe, x_oe}, 3'h0);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_write_primary();
    model_u.seen = 3'h0;
    xfer(2'h0, 2'h0, 8'h02, 8'h00, 8'h9F, 8'h81);
    chk("wr_bytes", {model_u.cap[0], model_u.cap[1]}, 16'h9F81);
    chk("wr_one_frame", model_u.ncap, 2);
    chk("wr_select", model_u.seen, 3'h1);
    chk("sck_period_17", model_u.period, 60);
  endtask
  task automatic t_read_secondary();
    model_u.seen = 3'h0;
    xfer(2'h1, 2'h0, 8'h01, 8'h02, 8'h0B, 8'h00);
    chk("rd_count", rd_q.size(), 2);
    chk("rd_bytes", {rd_q[0], rd_q[1]}, 16'hC3C3);
    chk("rd_select", model_u.seen, 3'h2);
  endtask
  task automatic t_refusals();
    logic [3:0] tab [4] = '{4'hC, 4'h8, 4'h3, 4'h2};
    foreach (tab[j]) begin
      xfer(tab[j][3:2], tab[j][1:0], 8'h01, 8'h00, 8'h00, 8'h00);
      chk("refused", nerr, 1);
    end
    xfer(2'h0, 2'h1, 8'h01, 8'h01, 8'h3B, 8'h00);
    chk("dual_out_default", nerr, 0);
  endtask
  task automatic t_sleep();
    @(negedge clk);
    sleep = 1;
    repeat (4) @(negedge clk);
    chk("sleep_pins", {req_ready, sck, mosi, cs0, cs1, cs2}, 6'h07);
    chk("sleep_float", {miso_oe, x_oe}, 3'h0);
    sleep = 0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_trust();
    model_u.seen = 3'h0;
    xfer(2'h2, 2'h0, 8'h01, 8'h01, 8'hD4, 8'h00);
    chk("trust_byte", rd_q.size() == 1 && rd_q[0] === 8'h5A, 1);
    chk("trust_select", model_u.seen, 3'h4);
    chk("sck_period_capped", model_u.period, 30);
    xfer(2'h2, 2'h2, 8'h01, 8'h01, 8'hD4, 8'h00);
    chk("trust_wide_refused", nerr, 1);
    xfer(2'h0, 2'h2, 8'h01, 8'h01, 8'h6B, 8'h00);
    chk("quad_strapped", nerr, 0);
  endtask
  initial begin
    {rst_n, resume_n, sleep, trust_strap, wide_strap, fast_ok, req_valid} = 7'h04;
    {rate, tgt, lanes, out_n, in_n, wdata} = 30'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1;
    restrap(1'b0, 1'b0, 2'h0, 1'b1);
    t_write_primary();
    t_read_secondary();
    t_refusals();
    t_sleep();
    restrap(1'b1, 1'b1, 2'h2, 1'b0);
    t_trust();
    end_of_test();
  end
  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    #5_000_000;
    miscompares++;
    end_of_test();
  end
endmodule
bind flash_tpm_serial_port port_assertions #(.LEN_W(LEN_W)) chk_u (.clk, .rst_n, .link_clk,
  .resume_well_reset_n, .sleep_state, .trust_module_on_serial, .wide_io_strap, .req_valid,
  .req_ready, .req_target, .req_lanes, .req_out_bytes, .wdata_take, .req_error,
  .serial_clock_out, .serial_clock_oe, .select_oe, .host_out_line, .host_out_line_oe,
  .host_in_line_oe, .primary_flash_select_n, .secondary_flash_select_n,
  .trust_module_select_n, .extra_data_lines_hi_oe);
